// ===== design/dacr_ctrl.sv
// Control logic of a dual simultaneous-sampling converter: range, filter, channel pair and averaging.
// Assumes register accesses come from same-clock logic and strap pins and start pin are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "dacr_defs.svh"

// What this block does
// - Two converters, eight channels each, sampled as simultaneous A/B pairs.
// - Range straps: 00 registers, 01 2.5 V, 10 5 V, 11 10 V.
// - Hardware mode applies strapped range to all channels from the next conversion.
// - Software mode configures range per channel.
// - Overrange bits set in both a register and its copy widen that channel's range by 20 percent, software mode only.
// - Filter codes 00, 01, 10 give options 1 to 3, software mode only.
// - Hardware mode pairs A channel n with B channel n.
// - Software mode pairs any A channel with any B channel.
// - Diagnostic channels reachable only in software mode.
// - Each selector picks among eight channels and one diagnostic selector output.
// - Hardware mode takes the first pair from pick pins at reset release.
// - Hardware mode samples pick pins during each conversion for the next pair.
// - Software mode takes the pair from a register.
// - Sequencer and burst stepping available in both modes.
// - Averaging ratio from pins in hardware mode, bits in software mode.
// - First sample on start edge, later samples on internal strobe.
// - Samples are averaged and decimated to one 16-bit result.
// - In burst, all samples of a pair finish before moving on.
// - Output rate falls in proportion to the averaging ratio.
// - Ratio code 000 is none, 001 to 111 are 2 to 128.
// - Range straps choose the mode; software mode uses registers.
// - Results are two's complement for every range.
module dacr_ctrl
  import dacr_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Strap and control pins
  input wire logic [1:0] range_strap_pins,
  input wire logic [2:0] channel_pick_pins,
  input wire logic [2:0] oversampling_ratio_pins,
  input wire logic conversion_start,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Converter core
  input wire logic raw_valid,
  input wire logic [DATA_W-1:0] raw_a,
  input wire logic [DATA_W-1:0] raw_b,
  output logic sample_strobe,
  output dacr_conv_sel_t sel_a,
  output dacr_conv_sel_t sel_b,
  output logic [1:0] front_lowpass_option,
  // Results and status
  output logic busy,
  output logic hw_mode,
  output logic result_valid,
  output logic [DATA_W-1:0] result_a,
  output logic [DATA_W-1:0] result_b
);
  localparam int ACC_W = DATA_W + 7;
  if (DATA_W != 16 || CHANNELS != 8) begin : g_bad_param
    $error("dacr_ctrl supports only 16-bit data and eight channels per group");
  end
  // ****************************************************************
  // State
  // ****************************************************************
  logic [1:0] strap_s1_q, strap_s2_q, strap_s2_d;
  logic [2:0] pick_s1_q, pick_s2_q, osp_s1_q, osp_s2_q;
  logic start_s1_q, start_s2_q, start_s3_q;
  logic [1:0] init_cnt_q, init_cnt_d;
  logic init_done_q, init_done_d;
  logic [15:0] cfg_q, cfg_d, chan_q, chan_d, rng_a_q, rng_a_d, rng_b_q, rng_b_d;
  logic [1:0] diag_q, diag_d, lpf_q, lpf_d;
  logic [7:0] ovr_q [4], ovr_d [4];
  dacr_state_t state_q, state_d;
  logic [2:0] pair_q, pair_d, seq_idx_q, seq_idx_d, os_q, os_d;
  logic [7:0] cnt_q, cnt_d;
  logic signed [ACC_W-1:0] acc_a_q, acc_a_d, acc_b_q, acc_b_d;
  logic [15:0] rdata_q, rdata_d;
  logic sample_q, sample_d, busy_q, busy_d, hw_q, hw_d, valid_q, valid_d;
  dacr_conv_sel_t sel_a_q, sel_a_d, sel_b_q, sel_b_d;
  logic [DATA_W-1:0] res_a_q, res_a_d, res_b_q, res_b_d;
  logic hw, start_edge, seq_en, burst_en;
  logic [2:0] os_code, seq_last;
  logic [7:0] cnt_next, target;
  // Builds the selector word for one converter; group 0 is A, group 1 is B.
  function automatic dacr_conv_sel_t pick_sel(input logic [3:0] code, input logic grp,
                                              input logic hwm);
    dacr_conv_sel_t s;
    logic [2:0] c;
    s = '0;
    c = code[2:0];
    if (code >= `DACR_DIAG_CODE && !hwm) begin
      s.chan = `DACR_DIAG_CODE;
      s.diag_src = diag_q[grp];
      s.range = `DACR_RANGE_10V;
    end else begin
      s.chan = {1'b0, c};
      if (hwm) begin
        s.range = strap_s2_q;
      end else begin
        s.range = grp ? rng_b_q[{c, 1'b0} +: 2] : rng_a_q[{c, 1'b0} +: 2];
        s.overrange = grp ? (ovr_q[1][c] & ovr_q[3][c]) : (ovr_q[0][c] & ovr_q[2][c]);
      end
    end
    return s;
  endfunction
  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    hw = strap_s2_q != `DACR_STRAP_SW;
    start_edge = start_s2_q && !start_s3_q;
    seq_en = cfg_q[`DACR_CFG_SEQ_BIT];
    burst_en = cfg_q[`DACR_CFG_BURST_BIT];
    seq_last = chan_q[`DACR_CHAN_LAST_LSB +: 3];
    os_code = hw ? osp_s2_q : cfg_q[`DACR_CFG_OS_LSB +: 3];
    cnt_next = cnt_q + 8'h01;
    target = 8'h01 << os_q;
    strap_s2_d = strap_s1_q;
    init_cnt_d = init_cnt_q;
    init_done_d = init_done_q;
    cfg_d = cfg_q;
    chan_d = chan_q;
    rng_a_d = rng_a_q;
    rng_b_d = rng_b_q;
    diag_d = diag_q;
    ovr_d = ovr_q;
    state_d = state_q;
    pair_d = pair_q;
    seq_idx_d = seq_idx_q;
    os_d = os_q;
    cnt_d = cnt_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    rdata_d = rdata_q;
    sample_d = 1'b0;
    busy_d = busy_q;
    hw_d = hw;
    valid_d = 1'b0;
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    lpf_d = hw ? `DACR_LPF_OPT1 : cfg_q[`DACR_CFG_LPF_LSB +: 2];
    res_a_d = res_a_q;
    res_b_d = res_b_q;
    // Initial pair is caught once the pick pins have passed the synchroniser.
    if (!init_done_q) begin
      if (init_cnt_q == `DACR_SYNC_SETTLE) begin
        pair_d = pick_s2_q;
        init_done_d = 1'b1;
      end else begin
        init_cnt_d = init_cnt_q + 2'h1;
      end
    end
    if (reg_wr_en) begin
      unique case (reg_addr)
        `DACR_OFS_CONFIG: begin
          cfg_d = reg_wdata;
          if (reg_wdata[`DACR_CFG_LPF_LSB +: 2] == `DACR_LPF_RSVD) begin
            cfg_d[`DACR_CFG_LPF_LSB +: 2] = cfg_q[`DACR_CFG_LPF_LSB +: 2];
          end
        end
        `DACR_OFS_CHAN: chan_d = reg_wdata;
        `DACR_OFS_RANGE_A: rng_a_d = reg_wdata;
        `DACR_OFS_RANGE_B: rng_b_d = reg_wdata;
        `DACR_OFS_DIAG: diag_d = reg_wdata[1:0];
        `DACR_OFS_OVR_A, `DACR_OFS_OVR_B, `DACR_OFS_OVR_A_COPY, `DACR_OFS_OVR_B_COPY: begin
          ovr_d[reg_addr[1:0]] = reg_wdata[7:0];
        end
        default: ;
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        `DACR_OFS_CONFIG: rdata_d = cfg_q;
        `DACR_OFS_CHAN: rdata_d = chan_q;
        `DACR_OFS_RANGE_A: rdata_d = rng_a_q;
        `DACR_OFS_RANGE_B: rdata_d = rng_b_q;
        `DACR_OFS_DIAG: rdata_d = {14'h0000, diag_q};
        `DACR_OFS_STATUS: rdata_d = {8'h00, busy_q, hw, seq_idx_q, os_code};
        `DACR_OFS_OVR_A, `DACR_OFS_OVR_B, `DACR_OFS_OVR_A_COPY, `DACR_OFS_OVR_B_COPY: begin
          rdata_d = {8'h00, ovr_q[reg_addr[1:0]]};
        end
        default: rdata_d = 16'h0000;
      endcase
    end
    unique case (state_q)
      DACR_IDLE: begin
        if (start_edge && init_done_q) begin
          busy_d = 1'b1;
          os_d = os_code;
          state_d = DACR_LOAD;
        end
      end
      DACR_LOAD: begin
        if (seq_en) begin
          sel_a_d = pick_sel({1'b0, seq_idx_q}, 1'b0, hw);
          sel_b_d = pick_sel({1'b0, seq_idx_q}, 1'b1, hw);
        end else if (hw) begin
          sel_a_d = pick_sel({1'b0, pair_q}, 1'b0, 1'b1);
          sel_b_d = pick_sel({1'b0, pair_q}, 1'b1, 1'b1);
        end else begin
          sel_a_d = pick_sel(chan_q[`DACR_CHAN_A_LSB +: 4], 1'b0, 1'b0);
          sel_b_d = pick_sel(chan_q[`DACR_CHAN_B_LSB +: 4], 1'b1, 1'b0);
        end
        cnt_d = 8'h00;
        acc_a_d = '0;
        acc_b_d = '0;
        state_d = DACR_SAMPLE;
      end
      DACR_SAMPLE: begin
        sample_d = 1'b1;
        if (hw) begin
          pair_d = pick_s2_q;
        end
        state_d = DACR_WAIT;
      end
      DACR_WAIT: begin
        if (raw_valid) begin
          acc_a_d = acc_a_q + ACC_W'(signed'(raw_a));
          acc_b_d = acc_b_q + ACC_W'(signed'(raw_b));
          cnt_d = cnt_next;
          state_d = (cnt_next == target) ? DACR_DONE : DACR_SAMPLE;
        end
      end
      DACR_DONE: begin
        res_a_d = DATA_W'(acc_a_q >>> os_q);
        res_b_d = DATA_W'(acc_b_q >>> os_q);
        valid_d = 1'b1;
        state_d = DACR_IDLE;
        busy_d = 1'b0;
        if (seq_en) begin
          seq_idx_d = (seq_idx_q == seq_last) ? 3'h0 : seq_idx_q + 3'h1;
          if (burst_en && seq_idx_q != seq_last) begin
            busy_d = 1'b1;
            state_d = DACR_LOAD;
          end
        end
      end
      default: state_d = DACR_IDLE;
    endcase
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      pick_s1_q <= '0;
      pick_s2_q <= '0;
      osp_s1_q <= '0;
      osp_s2_q <= '0;
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
      cfg_q <= `DACR_CFG_RST;
      chan_q <= `DACR_CHAN_RST;
      rng_a_q <= `DACR_RANGE_RST;
      rng_b_q <= `DACR_RANGE_RST;
      diag_q <= '0;
      ovr_q <= '{default: `DACR_OVR_RST};
      state_q <= DACR_IDLE;
      pair_q <= '0;
      seq_idx_q <= '0;
      os_q <= '0;
      cnt_q <= '0;
      acc_a_q <= '0;
      acc_b_q <= '0;
      rdata_q <= '0;
      sample_q <= 1'b0;
      busy_q <= 1'b0;
      hw_q <= 1'b0;
      valid_q <= 1'b0;
      sel_a_q <= '0;
      sel_b_q <= '0;
      lpf_q <= '0;
      res_a_q <= '0;
      res_b_q <= '0;
    end else begin
      strap_s1_q <= range_strap_pins;
      strap_s2_q <= strap_s2_d;
      pick_s1_q <= channel_pick_pins;
      pick_s2_q <= pick_s1_q;
      osp_s1_q <= oversampling_ratio_pins;
      osp_s2_q <= osp_s1_q;
      start_s1_q <= conversion_start;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
      init_cnt_q <= init_cnt_d;
      init_done_q <= init_done_d;
      cfg_q <= cfg_d;
      chan_q <= chan_d;
      rng_a_q <= rng_a_d;
      rng_b_q <= rng_b_d;
      diag_q <= diag_d;
      ovr_q <= ovr_d;
      state_q <= state_d;
      pair_q <= pair_d;
      seq_idx_q <= seq_idx_d;
      os_q <= os_d;
      cnt_q <= cnt_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      rdata_q <= rdata_d;
      sample_q <= sample_d;
      busy_q <= busy_d;
      hw_q <= hw_d;
      valid_q <= valid_d;
      sel_a_q <= sel_a_d;
      sel_b_q <= sel_b_d;
      lpf_q <= lpf_d;
      res_a_q <= res_a_d;
      res_b_q <= res_b_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign sample_strobe = sample_q;
  assign sel_a = sel_a_q;
  assign sel_b = sel_b_q;
  assign front_lowpass_option = lpf_q;
  assign busy = busy_q;
  assign hw_mode = hw_q;
  assign result_valid = valid_q;
  assign result_a = res_a_q;
  assign result_b = res_b_q;
endmodule
`default_nettype wire

// ===== shared/dacr_defs.svh
// Register offsets, field positions, reset values and codes of the converter control block.
// Assumes inclusion by bare name from files that also import dacr_pkg.
`ifndef DACR_DEFS_SVH
`define DACR_DEFS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define DACR_OFS_CONFIG 4'h2
`define DACR_OFS_CHAN 4'h3
`define DACR_OFS_RANGE_A 4'h4
`define DACR_OFS_RANGE_B 4'h5
`define DACR_OFS_DIAG 4'h6
`define DACR_OFS_STATUS 4'h7
`define DACR_OFS_OVR_A 4'h8
`define DACR_OFS_OVR_B 4'h9
`define DACR_OFS_OVR_A_COPY 4'hA
`define DACR_OFS_OVR_B_COPY 4'hB
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DACR_CFG_OS_LSB 0
`define DACR_CFG_LPF_LSB 3
`define DACR_CFG_SEQ_BIT 5
`define DACR_CFG_BURST_BIT 6
`define DACR_CHAN_A_LSB 0
`define DACR_CHAN_B_LSB 4
`define DACR_CHAN_LAST_LSB 8
`define DACR_CFG_RST 16'h0000
`define DACR_CHAN_RST 16'h0000
`define DACR_RANGE_RST 16'hFFFF
`define DACR_OVR_RST 8'h00
// ****************************************************************
// Codes and timing
// ****************************************************************
`define DACR_STRAP_SW 2'h0
`define DACR_RANGE_10V 2'h3
`define DACR_LPF_OPT1 2'h0
`define DACR_LPF_RSVD 2'h3
`define DACR_DIAG_CODE 4'h8
`define DACR_SYNC_SETTLE 2'h2
`endif

// ===== shared/dacr_pkg.sv
// Types shared by the converter control block and its bench.
// Assumes no other package.
package dacr_pkg;
  typedef enum logic [2:0] {
    DACR_IDLE,
    DACR_LOAD,
    DACR_SAMPLE,
    DACR_WAIT,
    DACR_DONE
  } dacr_state_t;

  typedef struct packed {
    logic [3:0] chan;
    logic diag_src;
    logic [1:0] range;
    logic overrange;
  } dacr_conv_sel_t;
endpackage

// ===== verif/dacr_core_model.sv
// Converter core stand-in: answers each sample request with one A/B sample pair.
// Assumes one request at a time and busy framing each conversion.
`timescale 1ns/1ps
`default_nettype none
module dacr_core_model #(
  parameter int LAT = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests and sample base values
  input wire logic sample_strobe,
  input wire logic busy,
  input wire logic [15:0] base_a,
  input wire logic [15:0] base_b,
  // Samples back
  output logic raw_valid,
  output logic [15:0] raw_a,
  output logic [15:0] raw_b
);
  int cnt;
  logic [15:0] k;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      k <= 16'h0000;
      raw_valid <= 1'b0;
      raw_a <= 16'h0000;
      raw_b <= 16'h0000;
    end else begin
      raw_valid <= 1'b0;
      raw_a <= ~raw_a;
      raw_b <= ~raw_b;
      if (!busy) k <= 16'h0000;
      if (sample_strobe) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) begin
        raw_valid <= 1'b1;
        raw_a <= base_a + k;
        raw_b <= base_b + k;
        k <= k + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/dacr_properties.sv
// Port-level checks of the converter control block.
// Assumes it is bound to dacr_ctrl from the bench top.
`timescale 1ns/1ps
`default_nettype none
module dacr_props
  import dacr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins and register port
  input wire logic [1:0] range_strap_pins,
  input wire logic conversion_start,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rdata,
  // Converter side and status
  input wire logic sample_strobe,
  input wire dacr_conv_sel_t sel_a,
  input wire dacr_conv_sel_t sel_b,
  input wire logic [1:0] front_lowpass_option,
  input wire logic busy,
  input wire logic hw_mode,
  input wire logic result_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_mode_strap: assert property ($stable(range_strap_pins)[*4] |->
    hw_mode == (range_strap_pins != 2'h0)) else $error("mode differs from strap");
  a_hw_filter: assert property (hw_mode[*3] |-> front_lowpass_option == 2'h0)
    else $error("filter option set in hardware mode");
  a_hw_pair: assert property (hw_mode && sample_strobe |->
    sel_a.chan == sel_b.chan) else $error("unequal pair in hardware mode");
  a_hw_no_diag: assert property (hw_mode && sample_strobe |->
    !sel_a.chan[3] && !sel_b.chan[3]) else $error("diagnostic in hardware mode");
  a_hw_range: assert property (hw_mode && sample_strobe |->
    sel_a.range == range_strap_pins && sel_b.range == range_strap_pins
    && !sel_a.overrange && !sel_b.overrange) else $error("strap range not applied");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample request longer than one cycle");
  a_start_strobe: assert property ($rose(conversion_start) && !busy |->
    ##[3:8] sample_strobe) else $error("start edge gave no sample request");
  a_end_result: assert property ($fell(busy) |-> result_valid)
    else $error("busy fell without a result");
  a_rdata_hold: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  c_hw_conv: cover property (hw_mode && sample_strobe);
  c_diag: cover property (sample_strobe && sel_a.chan == 4'h8);
  c_burst: cover property (result_valid && busy);
  c_ovr: cover property (sample_strobe && sel_a.overrange);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench of the converter control block.
// Assumes the core stand-in and the port checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dacr_pkg::*;
  logic clock, raw_valid, sample_strobe, busy, hw_mode, result_valid;
  logic rst = 1'b1;
  logic conversion_start = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [1:0] range_strap_pins = 2'h0;
  logic [2:0] channel_pick_pins = 3'h2;
  logic [2:0] oversampling_ratio_pins = 3'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] base_a = 16'h1234;
  logic [15:0] base_b = 16'hA5A5;
  logic [15:0] reg_rdata, raw_a, raw_b, result_a, result_b;
  logic [1:0] front_lowpass_option;
  logic [15:0] lpf_exp [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0002};
  dacr_conv_sel_t sel_a, sel_b;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int ns, nr;
  dacr_ctrl dacr_ctrl_i (.clock(clock), .rst(rst), .range_strap_pins(range_strap_pins),
    .channel_pick_pins(channel_pick_pins), .oversampling_ratio_pins(oversampling_ratio_pins),
    .conversion_start(conversion_start), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_a(raw_a), .raw_b(raw_b), .sample_strobe(sample_strobe), .sel_a(sel_a), .sel_b(sel_b),
    .front_lowpass_option(front_lowpass_option), .busy(busy), .hw_mode(hw_mode),
    .result_valid(result_valid), .result_a(result_a), .result_b(result_b));
  dacr_core_model #(.LAT(3)) dacr_core_model_i (.clock(clock), .rst(rst),
    .sample_strobe(sample_strobe), .busy(busy), .base_a(base_a), .base_b(base_b),
    .raw_valid(raw_valid), .raw_a(raw_a), .raw_b(raw_b));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    @(negedge clock);
    chk("register", reg_rdata, exp);
  endtask
  // Starts one conversion and counts sample requests and results until busy drops.
  task automatic conv();
    ns = 0;
    nr = 0;
    @(negedge clock);
    conversion_start = 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(negedge clock);
      if (n == 3) conversion_start = 1'b0;
      ns += int'(sample_strobe === 1'b1);
      nr += int'(result_valid === 1'b1);
      if (n > 8 && busy === 1'b0) break;
    end
  endtask
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    rd(4'h4, 16'hFFFF);
    for (int i = 8; i < 12; i++) rd(4'(i), 16'h0000);
    rd(4'hF, 16'h0000);
    wr(4'h8, 16'h1204);
    rd(4'h8, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      wr(4'h2, 16'(i << 3));
      repeat (2) @(negedge clock);
      chk("filter", {14'h0, front_lowpass_option}, lpf_exp[i]);
    end
    $display("test registers done");
    wr(4'h3, 16'h0052);
    wr(4'h4, 16'hFFDF);
    conv();
    chk("pair", {8'h0, sel_a.chan, sel_b.chan}, 16'h0025);
    chk("ranges", {12'h0, sel_a.range, sel_b.range}, 16'h0007);
    chk("half ovr", {15'h0, sel_a.overrange}, 16'h0000);
    chk("result", result_a, 16'h1234);
    chk("counts", 16'(ns * 16 + nr), 16'h0011);
    wr(4'hA, 16'h0004);
    wr(4'h9, 16'h0020);
    wr(4'hB, 16'h0020);
    conv();
    chk("ovr", {14'h0, sel_a.overrange, sel_b.overrange}, 16'h0003);
    wr(4'h6, 16'h0001);
    wr(4'h3, 16'h0058);
    conv();
    chk("diag", {7'h0, sel_a.chan, sel_a.diag_src, sel_b.chan}, 16'h0115);
    $display("test software pair done");
    wr(4'h2, 16'h0002);
    base_a = 16'hFFF0;
    base_b = 16'h0010;
    conv();
    chk("avg a", result_a, 16'hFFF1);
    chk("avg b", result_b, 16'h0011);
    chk("os counts", 16'(ns * 16 + nr), 16'h0041);
    wr(4'h2, 16'h0061);
    wr(4'h3, 16'h0252);
    conv();
    chk("burst", 16'(ns * 16 + nr), 16'h0063);
    $display("test averaging done");
    wr(4'h2, 16'h0008);
    range_strap_pins = 2'h3;
    repeat (4) @(negedge clock);
    chk("hw", {15'h0, hw_mode}, 16'h0001);
    chk("hw filter", {14'h0, front_lowpass_option}, 16'h0000);
    rd(4'h7, 16'h0041);
    fork
      conv();
      begin
        repeat (2) @(negedge clock);
        channel_pick_pins = 3'h6;
      end
    join
    chk("hw pair", {8'h0, sel_a.chan, sel_b.chan}, 16'h0022);
    chk("hw range", {13'h0, sel_a.range, sel_a.overrange}, 16'h0006);
    chk("hw os", 16'(ns * 16 + nr), 16'h0021);
    for (int s = 1; s < 3; s++) begin
      range_strap_pins = 2'(s);
      repeat (4) @(negedge clock);
      conv();
      chk("next pair", {8'h0, sel_a.chan, sel_b.chan}, 16'h0066);
      chk("strap", {14'h0, sel_b.range}, 16'(s));
    end
    $display("test hardware mode done");
    end_of_test();
  end
endmodule
bind dacr_ctrl dacr_props dacr_props_i (.clock(clock), .rst(rst),
  .range_strap_pins(range_strap_pins), .conversion_start(conversion_start),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
  .sel_a(sel_a), .sel_b(sel_b), .front_lowpass_option(front_lowpass_option),
  .busy(busy), .hw_mode(hw_mode), .result_valid(result_valid));
`default_nettype wire
